// >>> design/pscfg_pkg.sv
// Package: register map, field layout, reset values and timing for the PLL synthesis configuration block
package pscfg_pkg;

    // Register indices as printed; byte address is four times the index
    localparam logic [11:0] PSCFG_IDX_MULT     = 12'h034;
    localparam logic [11:0] PSCFG_IDX_REF_DIVISOR   = 12'h035;
    localparam logic [11:0] PSCFG_IDX_POST_DIVISOR  = 12'h036;
    localparam logic [11:0] PSCFG_IDX_STATUS   = 12'h037;
    localparam logic [11:0] PSCFG_IDX_CLKSEL   = 12'h039;
    localparam logic [11:0] PSCFG_IDX_APIRL    = 12'h2F5;
    localparam logic [11:0] PSCFG_IDX_TEST3    = 12'h2F6;
    localparam logic [11:0] PSCFG_IDX_RSVD     = 12'h2F7;
    localparam logic [11:0] PSCFG_IDX_TRIMH    = 12'h2F8;
    localparam logic [11:0] PSCFG_IDX_TRIML    = 12'h2F9;
    localparam logic [11:0] PSCFG_IDX_OSC      = 12'h2FA;
    localparam logic [11:0] PSCFG_IDX_WLOCK    = 12'h2FB;
    localparam logic [11:0] PSCFG_IDX_TEST2    = 12'h2FC;
    localparam int          PSCFG_ADDR_W       = 14;

    // Field positions
    localparam int PSCFG_MULT_LSB      = 0;
    localparam int PSCFG_MULT_W        = 6;
    localparam int PSCFG_VCORNG_LSB    = 6;
    localparam int PSCFG_REF_DIVISOR_LSB    = 0;
    localparam int PSCFG_REF_DIVISOR_W      = 4;
    localparam int PSCFG_REFRNG_LSB    = 6;
    localparam int PSCFG_POST_DIVISOR_W     = 5;
    localparam int PSCFG_ST_LOCK_BIT   = 3;
    localparam int PSCFG_ST_OSCQ_BIT   = 0;
    localparam int PSCFG_CLKSEL_BIT    = 7;
    localparam int PSCFG_OSCEN_BIT     = 7;
    localparam int PSCFG_WLOCK_BIT     = 0;
    localparam int PSCFG_TRIMH_MASK_W  = 8;

    // Reset values
    localparam logic [7:0] PSCFG_RST_MULT    = 8'h00;
    localparam logic [7:0] PSCFG_RST_REF_DIVISOR  = 8'h0F;
    localparam logic [7:0] PSCFG_RST_POST_DIVISOR = 8'h03;
    localparam logic [7:0] PSCFG_RST_CLKSEL  = 8'h80;
    localparam logic [7:0] PSCFG_RST_OSC     = 8'h00;
    localparam logic [7:0] PSCFG_RST_WLOCK   = 8'h00;
    localparam logic [7:0] PSCFG_RST_BYTE    = 8'h00;
    localparam logic [7:0] PSCFG_TRIMH_WMASK = 8'hFB;

    // Fixed ratios
    localparam logic [5:0] PSCFG_UNLOCK_POST = 6'h04;

    // Loop filter codes
    localparam logic [1:0] PSCFG_FILT_1TO2   = 2'h0;

    // Timing
    localparam int PSCFG_CLK_MHZ        = 40;
    localparam int PSCFG_LOCK_SETTLE_US = 10;
    localparam int PSCFG_LOCK_SETTLE_CY = PSCFG_LOCK_SETTLE_US * PSCFG_CLK_MHZ;

    // Configuration handed to the analog synthesizer and clock tree
    typedef struct packed {
        logic [6:0]  vco_mult;      // VCO / reference ratio
        logic [1:0]  vco_gain;      // VCO range code
        logic [4:0]  ref_div;       // Oscillator / reference ratio
        logic        ref_from_osc;  // 1: external oscillator, 0: internal RC
        logic [1:0]  loop_filter;   // Loop filter range code
        logic [5:0]  post_ratio;    // VCO / PLL output ratio
        logic [6:0]  bus_ratio;     // PLL output ratio times two
        logic        pll_is_sys;    // PLL drives the system clock
    } pscfg_cfg_s;

endpackage

// >>> design/pscfg_top.sv
// PLL synthesis configuration: multiplier, reference divider, source choice and write lock over APB
// What this block does
// - Multiplier and reference divider writes take effect only when unlocked and PLL clock selected.
// - Accepted multiplier write clears lock and oscillator-qualified status.
// - Accepted divider write clears lock and oscillator-qualified status.
// - Locked VCO runs at twice reference times multiplier plus one.
// - VCO range code 00 is 32-48 MHz, 01 is 48-64 MHz.
// - External oscillator reference is oscillator divided by divisor plus one.
// - Without external oscillator the internal 1 MHz RC is the reference.
// - Internal RC reference forces the 1-2 MHz loop filter; range field ignored.
// - External reference: range field selects loop filter in four bands.
// - A post divider sets VCO to PLL output ratio.
// - Locked output is VCO over post divisor plus one; unlocked VCO over four.
// - PLL as system clock gives bus clock at half PLL output.
`timescale 1ns/1ps
module pscfg_top
    import pscfg_pkg::*;
#(
    parameter int LOCK_SETTLE_CY = PSCFG_LOCK_SETTLE_CY
) (
    // Clock and reset
    input  wire logic                    mclk_i,
    input  wire logic                    rst_b_i,
    // APB slave
    input  wire logic                    psel_i,
    input  wire logic                    penable_i,
    input  wire logic                    pwrite_i,
    input  wire logic [PSCFG_ADDR_W-1:0] paddr_i,
    input  wire logic [31:0]             pwdata_i,
    output logic      [31:0]             prdata_o,
    output logic                         pready_o,
    output logic                         pslverr_o,
    // Analog synthesizer status pins
    input  wire logic                    pll_lock_det_i,
    input  wire logic                    osc_detect_i,
    // Synthesizer configuration and status
    output pscfg_cfg_s                   pll_cfg_o,
    output logic                         pll_locked_o,
    output logic                         osc_qualified_o
);

    localparam int CNT_W = $clog2(LOCK_SETTLE_CY + 1);
    localparam logic [CNT_W-1:0] SETTLE_MAX = CNT_W'(LOCK_SETTLE_CY);

    // Register state
    logic [7:0]       mult_q, ref_divisor_q, post_divisor_q, clksel_q, osc_q, wlock_q;
    logic [7:0]       apirl_q, trimh_q, triml_q;
    logic             lock_q, oscq_q;
    logic [CNT_W-1:0] settle_q;
    logic [1:0]       pin_meta_q, pin_sync_q;
    logic [31:0]      prdata_q;

    // Bus decode
    wire        access   = psel_i & penable_i;
    wire        wr_en    = access & pwrite_i;
    wire        rd_en    = access & ~pwrite_i;
    wire [11:0] idx      = paddr_i[PSCFG_ADDR_W-1:2];
    wire        aligned  = (paddr_i[1:0] == 2'h0);
    // One comparator per mapped register; hit bit 0 is the last entry of this table and the bits count up towards the first
    localparam int NREG = 13;
    localparam logic [NREG-1:0][11:0] REG_IDX = {
        PSCFG_IDX_TEST2,
        PSCFG_IDX_WLOCK,
        PSCFG_IDX_OSC,
        PSCFG_IDX_TRIML,
        PSCFG_IDX_TRIMH,
        PSCFG_IDX_RSVD,
        PSCFG_IDX_TEST3,
        PSCFG_IDX_APIRL,
        PSCFG_IDX_CLKSEL,
        PSCFG_IDX_STATUS,
        PSCFG_IDX_POST_DIVISOR,
        PSCFG_IDX_REF_DIVISOR,
        PSCFG_IDX_MULT
    };
    logic [NREG-1:0] hit;
    for (genvar e = 0; e < NREG; e++) begin : g_hit
        assign hit[e] = aligned & (idx == REG_IDX[e]);
    end
    wire        hit_mult = hit[0];
    wire        hit_rdiv = hit[1];
    wire        hit_post = hit[2];
    wire        hit_stat = hit[3];
    wire        hit_csel = hit[4];
    wire        hit_apil = hit[5];
    wire        hit_trmh = hit[8];
    wire        hit_trml = hit[9];
    wire        hit_osc  = hit[10];
    wire        hit_wlck = hit[11];
    // Reserved and test slots only answer without error and read zero
    wire        mapped   = |hit;

    wire        pll_sel   = clksel_q[PSCFG_CLKSEL_BIT];
    wire        osc_en    = osc_q[PSCFG_OSCEN_BIT];
    wire        synth_wok = ~wlock_q[PSCFG_WLOCK_BIT] & pll_sel;
    wire        wr_mult   = wr_en & hit_mult & synth_wok;
    wire        wr_rdiv   = wr_en & hit_rdiv & synth_wok;
    // post divider writable only with PLL selected
    wire        wr_post   = wr_en & hit_post & pll_sel;
    wire        wr_csel   = wr_en & hit_csel;
    wire        wr_osc    = wr_en & hit_osc;
    wire        wr_wlck   = wr_en & hit_wlck;
    wire        wr_apil   = wr_en & hit_apil;
    wire        wr_trmh   = wr_en & hit_trmh;
    wire        wr_trml   = wr_en & hit_trml;
    wire        relock    = wr_mult | wr_rdiv;
    wire        lock_det  = pin_sync_q[0];
    wire        osc_det   = pin_sync_q[1];
    wire [7:0]  stat_img  = {4'h0, lock_q, 2'h0, oscq_q};

    // Read mux
    logic [7:0] rd_byte;
    always_comb begin
        if (hit_mult) begin
            rd_byte = mult_q;
        end else if (hit_rdiv) begin
            rd_byte = ref_divisor_q;
        end else if (hit_post) begin
            rd_byte = post_divisor_q;
        end else if (hit_stat) begin
            rd_byte = stat_img;
        end else if (hit_csel) begin
            rd_byte = clksel_q;
        end else if (hit_apil) begin
            rd_byte = apirl_q;
        end else if (hit_trmh) begin
            rd_byte = trimh_q;
        end else if (hit_trml) begin
            rd_byte = triml_q;
        end else if (hit_osc) begin
            rd_byte = osc_q;
        end else if (hit_wlck) begin
            rd_byte = wlock_q;
        end else begin
            rd_byte = PSCFG_RST_BYTE;
        end
    end

    // Zero wait states; unmapped or misaligned addresses answer with an error
    assign pready_o  = 1'b1;
    assign pslverr_o = access & ~mapped;
    assign prdata_o  = prdata_q;
    wire [31:0] prdata_d = {24'h00_0000, rd_byte};

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            prdata_q <= 32'h0000_0000;
        end else if (rd_en) begin
            prdata_q <= prdata_d;
        end
    end

    // Status pins come from the analog domain; only the second flop of each pair is read
    wire [1:0] pin_raw = {osc_detect_i, pll_lock_det_i};
    for (genvar g = 0; g < 2; g++) begin : g_pin_sync
        always_ff @(posedge mclk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                pin_meta_q[g] <= 1'b0;
                pin_sync_q[g] <= 1'b0;
            end else begin
                pin_meta_q[g] <= pin_raw[g];
                pin_sync_q[g] <= pin_meta_q[g];
            end
        end
    end

    // Next register values; each register loads only on its own strobe
    wire [7:0] mult_d    = wr_mult ? pwdata_i[7:0] : mult_q;
    wire [7:0] ref_divisor_d  = wr_rdiv ? (pwdata_i[7:0] & 8'hCF) : ref_divisor_q;
    wire [7:0] post_divisor_d = wr_post ? {3'h0, pwdata_i[PSCFG_POST_DIVISOR_W-1:0]} : post_divisor_q;
    wire [7:0] clksel_d  = wr_csel ? (pwdata_i[7:0] & 8'hCF) : clksel_q;
    wire [7:0] osc_d     = wr_osc ? pwdata_i[7:0] : osc_q;
    wire [7:0] wlock_d   = wr_wlck ? {7'h00, pwdata_i[PSCFG_WLOCK_BIT]} : wlock_q;
    wire [7:0] apirl_d   = wr_apil ? pwdata_i[7:0] : apirl_q;
    wire [7:0] trimh_d   = wr_trmh ? (pwdata_i[7:0] & PSCFG_TRIMH_WMASK) : trimh_q;
    wire [7:0] triml_d   = wr_trml ? pwdata_i[7:0] : triml_q;

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mult_q <= PSCFG_RST_MULT;
        end else begin
            mult_q <= mult_d;
        end
    end

    // gated divider write; bits 5:4 unimplemented
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ref_divisor_q <= PSCFG_RST_REF_DIVISOR;
        end else begin
            ref_divisor_q <= ref_divisor_d;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            post_divisor_q <= PSCFG_RST_POST_DIVISOR;
        end else begin
            post_divisor_q <= post_divisor_d;
        end
    end

    // Clock select; bits 5:4 unimplemented
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            clksel_q <= PSCFG_RST_CLKSEL;
        end else begin
            clksel_q <= clksel_d;
        end
    end

    // Oscillator control
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            osc_q <= PSCFG_RST_OSC;
        end else begin
            osc_q <= osc_d;
        end
    end

    // Write lock keeps only its one bit
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wlock_q <= PSCFG_RST_WLOCK;
        end else begin
            wlock_q <= wlock_d;
        end
    end

    // Autonomous period reload, low byte
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            apirl_q <= PSCFG_RST_BYTE;
        end else begin
            apirl_q <= apirl_d;
        end
    end

    // RC trim high; bit 2 unimplemented
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            trimh_q <= PSCFG_RST_BYTE;
        end else begin
            trimh_q <= trimh_d;
        end
    end

    // RC trim low
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            triml_q <= PSCFG_RST_BYTE;
        end else begin
            triml_q <= triml_d;
        end
    end

    wire restart = relock | ~lock_det;

    // Settle counter runs while the detector holds high and saturates at the settle time
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            settle_q <= '0;
        end else if (restart) begin
            settle_q <= '0;
        end else if (settle_q != SETTLE_MAX) begin
            settle_q <= settle_q + 1'b1;
        end
    end

    // Lock is declared only after the detector has held high for the settle time.
    // A relock write wins over the detector so stale lock never survives a new setting.
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            lock_q <= 1'b0;
        end else if (restart) begin
            lock_q <= 1'b0;
        end else begin
            lock_q <= (settle_q == SETTLE_MAX);
        end
    end

    // Oscillator qualification relies on the VCO, so it needs lock first
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            oscq_q <= 1'b0;
        end else if (restart) begin
            oscq_q <= 1'b0;
        end else begin
            oscq_q <= lock_q & osc_en & osc_det;
        end
    end

    assign pll_locked_o    = lock_q;
    assign osc_qualified_o = oscq_q;

    // Derived configuration
    wire [5:0] mult_f   = mult_q[PSCFG_MULT_LSB +: PSCFG_MULT_W];
    wire [3:0] rdiv_f   = ref_divisor_q[PSCFG_REF_DIVISOR_LSB +: PSCFG_REF_DIVISOR_W];
    wire [1:0] rrng_f   = ref_divisor_q[PSCFG_REFRNG_LSB +: 2];
    wire [4:0] post_f   = post_divisor_q[PSCFG_POST_DIVISOR_W-1:0];

    // VCO ratio 2 x (multiplier + 1)
    wire [6:0] vco_mult = {mult_f, 1'b0} + 7'h02;
    wire [4:0] ext_div  = {1'b0, rdiv_f} + 5'h01;
    wire [4:0] ref_div  = osc_en ? ext_div : 5'h01;
    wire [1:0] filt     = osc_en ? rrng_f : PSCFG_FILT_1TO2;
    wire [5:0] lock_pr  = {1'b0, post_f} + 6'h01;
    wire [5:0] post_r   = lock_q ? lock_pr : PSCFG_UNLOCK_POST;
    // bus clock half of PLL output
    wire [6:0] bus_r    = {post_r, 1'b0};

    // Next configuration word, one field at a time
    pscfg_cfg_s cfg_d;
    assign cfg_d.vco_mult     = vco_mult;
    // range code passed as written; reserved codes are software's fault
    assign cfg_d.vco_gain     = mult_q[PSCFG_VCORNG_LSB +: 2];
    assign cfg_d.ref_div      = ref_div;
    assign cfg_d.ref_from_osc = osc_en;
    assign cfg_d.loop_filter  = filt;
    assign cfg_d.post_ratio   = post_r;
    assign cfg_d.bus_ratio    = bus_r;
    assign cfg_d.pll_is_sys   = pll_sel;

    // Registered so the analog side never sees decode glitches
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pll_cfg_o <= '0;
        end else begin
            pll_cfg_o <= cfg_d;
        end
    end

endmodule

// >>> tb/pscfg_top_asserts.sv
// Port-level assertions for the PLL synthesis configuration block
`timescale 1ns/1ps
module pscfg_top_asserts
    import pscfg_pkg::*;
(
    // Clock, reset and bus
    input wire logic                    mclk_i,
    input wire logic                    rst_b_i,
    input wire logic                    psel_i,
    input wire logic                    penable_i,
    input wire logic                    pwrite_i,
    input wire logic [PSCFG_ADDR_W-1:0] paddr_i,
    input wire logic [31:0]             pwdata_i,
    // Synthesizer side
    input wire pscfg_cfg_s              pll_cfg_o,
    input wire logic                    pll_locked_o,
    input wire logic                    osc_qualified_o
);
    // Shadows of lock and select bits, since only the ports are visible
    logic        wlock_q;
    logic        pll_clock_select_q;
    wire         wr_acc = psel_i && penable_i && pwrite_i && paddr_i[1:0] == 2'b00;
    wire  [11:0] idx    = paddr_i[13:2];
    wire         ok_w   = wr_acc && !wlock_q && pll_clock_select_q;
    wire         rf_w   = wr_acc && !ok_w && (idx == PSCFG_IDX_MULT || idx == PSCFG_IDX_REF_DIVISOR);

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wlock_q  <= 1'b0;
            pll_clock_select_q <= 1'b1;
        end else if (wr_acc && idx == PSCFG_IDX_WLOCK) begin
            wlock_q  <= pwdata_i[0];
        end else if (wr_acc && idx == PSCFG_IDX_CLKSEL) begin
            pll_clock_select_q <= pwdata_i[7];
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_mult_wr;
        ok_w && idx == PSCFG_IDX_MULT;
    endsequence
    sequence s_div_wr;
        ok_w && idx == PSCFG_IDX_REF_DIVISOR;
    endsequence
    sequence s_cleared;
        !pll_locked_o && !osc_qualified_o;
    endsequence

    a_mult_clear:
        assert property (s_mult_wr |-> ##[1:2] s_cleared) else $error("multiplier write left status set");
    a_div_clear:
        assert property (s_div_wr |-> ##[1:2] s_cleared) else $error("divider write left status set");
    a_vco_ratio:
        assert property (s_mult_wr |-> ##2 pll_cfg_o.vco_mult == 7'(2 * ($past(pwdata_i[5:0], 2) + 1)))
        else $error("vco ratio wrong");
    a_vco_range:
        assert property (s_mult_wr |-> ##2 pll_cfg_o.vco_gain == $past(pwdata_i[7:6], 2)) else $error("vco range wrong");
    a_locked_hold:
        assert property (rf_w |-> ##2 $stable({pll_cfg_o.vco_mult, pll_cfg_o.vco_gain, pll_cfg_o.ref_div,
            pll_cfg_o.loop_filter})) else $error("refused write changed config");
    a_rc_ref:
        assert property (!pll_cfg_o.ref_from_osc && $past(rst_b_i) |-> pll_cfg_o.ref_div == 5'h01
            && pll_cfg_o.loop_filter == 2'h0) else $error("internal reference config wrong");
    a_post_unlock:
        assert property (!pll_locked_o && !$past(pll_locked_o) && $past(rst_b_i) |-> pll_cfg_o.post_ratio == 6'h04)
        else $error("unlocked post ratio wrong");
    a_bus_half:
        assert property (pll_cfg_o.bus_ratio == {pll_cfg_o.post_ratio, 1'b0}) else $error("bus ratio wrong");
    a_oscq_lock:
        assert property (osc_qualified_o |-> pll_locked_o) else $error("oscillator qualified without lock");
    a_cfg_quiet:
        assert property ((!psel_i && rst_b_i)[*3] |-> $stable({pll_cfg_o.vco_mult, pll_cfg_o.vco_gain, pll_cfg_o.ref_div,
            pll_cfg_o.loop_filter, pll_cfg_o.pll_is_sys})) else $error("config moved without access");
endmodule

// >>> tb/test_pll_synth_ref_divider_config.sv
// Self-checking bench for the PLL synthesis configuration block
`timescale 1ns/1ps
`define CHK(e, g) begin compares++; if ((e) !== (g)) begin errors++; \
    $display("unexpected at %0t: exp %h got %h", $time, e, g); end end
module test_pll_synth_ref_divider_config
    import pscfg_pkg::*;
();
    logic                    mclk_i, rst_b_i, psel, penable, pwrite, lock_det, osc_det, pready, pslverr;
    logic [PSCFG_ADDR_W-1:0] paddr;
    logic [31:0]             pwdata, prdata;
    logic                    locked, oscq;
    pscfg_cfg_s              cfg;
    logic [32:0]             exp_q[$];
    logic [32:0]             ev;
    logic                    rd_pend = 1'b0;
    logic                    err_s = 1'b0;
    int                      errors = 0, compares = 0, seed, n;
    logic [7:0]              d, m, r;

    // Short lock settle keeps the run brief
    pscfg_top #(.LOCK_SETTLE_CY(4)) dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .pll_lock_det_i(lock_det), .osc_detect_i(osc_det), .pll_cfg_o(cfg),
        .pll_locked_o(locked), .osc_qualified_o(oscq));

    initial begin
        mclk_i = 1'b0;
        forever #12.5 mclk_i = ~mclk_i;
    end

    // Read data is registered, so it is taken one edge after the access
    always @(posedge mclk_i) begin
        if (rd_pend) begin
            ev = (exp_q.size() > 0) ? exp_q.pop_front() : 'x;
            `CHK(ev, {err_s, prdata})
        end
        rd_pend <= psel && penable && !pwrite && rst_b_i;
        err_s   <= pslverr;
    end

    task automatic finish_test;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] wd, input logic [32:0] e);
        int k;
        if (!w) exp_q.push_back(e);
        @(posedge mclk_i);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= {a, 2'b00};
        pwdata  <= {24'h000000, wd};
        @(posedge mclk_i);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge mclk_i);
            k++;
        end while (!pready && k < 20);
        if (!pready) begin
            errors++;
            finish_test();
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] wd);
        apb(1'b1, a, wd, 33'h0);
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00, {25'h0, e});
    endtask

    task automatic settle;
        repeat (2) @(posedge mclk_i);
        #1;
    endtask

    task automatic wait_lock;
        n = 0;
        while (!(locked && oscq) && n < 50) begin
            @(posedge mclk_i);
            n++;
        end
        #1;
        if (n >= 50) begin
            errors++;
            finish_test();
        end
    endtask

    initial begin
        seed = 80;
        {rst_b_i, psel, penable, pwrite, lock_det, osc_det} = 6'h00;
        paddr  = '0;
        pwdata = 32'h0;
        repeat (16) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        settle();
        `CHK(cfg, {7'h02, 2'h0, 5'h01, 1'b0, 2'h0, 6'h04, 7'h08, 1'b1})
        rd(PSCFG_IDX_MULT, 8'h00);
        rd(PSCFG_IDX_REF_DIVISOR, 8'h0F);
        rd(PSCFG_IDX_POST_DIVISOR, 8'h03);
        rd(PSCFG_IDX_CLKSEL, 8'h80);
        rd(PSCFG_IDX_STATUS, 8'h00);
        for (int i = 0; i < 4; i++) begin
            // 1 MHz reference, so range code 00 up to 48 MHz and 01 above
            m[5:0] = 6'h0F + (6'($random(seed)) & 6'h0F);
            m[7:6] = (m[5:0] > 6'h17) ? 2'h1 : 2'h0;
            wr(PSCFG_IDX_MULT, m);
            rd(PSCFG_IDX_MULT, m);
            settle();
            `CHK({cfg.vco_gain, cfg.vco_mult}, {m[7:6], 7'(2 * (m[5:0] + 1))})
        end
        wr(PSCFG_IDX_OSC, 8'h00);
        r = 8'($random(seed));
        wr(PSCFG_IDX_REF_DIVISOR, r);
        rd(PSCFG_IDX_REF_DIVISOR, r & 8'hCF);
        settle();
        `CHK({cfg.ref_from_osc, cfg.ref_div, cfg.loop_filter}, 8'h04)
        wr(PSCFG_IDX_OSC, 8'h80);
        for (int i = 0; i < 4; i++) begin
            // oscillator taken as 8 MHz, so the band follows the divisor
            r[3:0] = 4'($random(seed)) & 4'h7;
            r[7:4] = (r[3:0] == 4'h0) ? 4'h8 : ((r[3:0] < 4'h3) ? 4'h4 : 4'h0);
            wr(PSCFG_IDX_REF_DIVISOR, r);
            settle();
            `CHK({cfg.ref_from_osc, cfg.ref_div, cfg.loop_filter}, {1'b1, 5'(r[3:0] + 1), r[7:6]})
        end
        d = 8'($random(seed)) & 8'h1F;
        wr(PSCFG_IDX_POST_DIVISOR, d);
        @(posedge mclk_i);
        lock_det <= 1'b1;
        osc_det  <= 1'b1;
        wait_lock();
        rd(PSCFG_IDX_STATUS, 8'h09);
        settle();
        `CHK({cfg.post_ratio, cfg.bus_ratio}, {6'(d + 1), 7'(2 * (d + 1))})
        m = m ^ 8'h01;
        wr(PSCFG_IDX_MULT, m);
        rd(PSCFG_IDX_STATUS, 8'h00);
        wait_lock();
        wr(PSCFG_IDX_REF_DIVISOR, r);
        rd(PSCFG_IDX_STATUS, 8'h00);
        wait_lock();
        // Refused writes must neither land nor disturb lock
        wr(PSCFG_IDX_WLOCK, 8'h01);
        wr(PSCFG_IDX_MULT, ~m);
        wr(PSCFG_IDX_REF_DIVISOR, ~r);
        rd(PSCFG_IDX_MULT, m);
        rd(PSCFG_IDX_REF_DIVISOR, r & 8'hCF);
        rd(PSCFG_IDX_STATUS, 8'h09);
        wr(PSCFG_IDX_WLOCK, 8'h00);
        wr(PSCFG_IDX_CLKSEL, 8'h00);
        wr(PSCFG_IDX_MULT, ~m);
        rd(PSCFG_IDX_MULT, m);
        wr(PSCFG_IDX_CLKSEL, 8'h80);
        @(posedge mclk_i);
        lock_det <= 1'b0;
        settle();
        settle();
        `CHK(cfg.post_ratio, PSCFG_UNLOCK_POST)
        apb(1'b0, 12'h100, 8'h00, {1'b1, 32'h0});
        wr(12'h100, 8'hFF);
        @(posedge mclk_i);
        rst_b_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        rd(PSCFG_IDX_MULT, 8'h00);
        settle();
        finish_test();
    end
endmodule

bind pscfg_top pscfg_top_asserts u_chk (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pll_cfg_o(pll_cfg_o),
    .pll_locked_o(pll_locked_o), .osc_qualified_o(osc_qualified_o));
